// ---- verilog/sac_pkg.sv ----
// constants and types of the setpoint alarm comparator
// assumes a 100 MHz system clock and an external 0.1 s tick
package sac_pkg;

  // data widths and channel count
  localparam int DATA_W  = 32;
  localparam int TIME_W  = 16;
  localparam int NRELAY  = 7;
  localparam int ADDR_W  = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_HIGH      = 8'h04;
  localparam logic [7:0] ADDR_LOW       = 8'h08;
  localparam logic [7:0] ADDR_DEADBAND  = 8'h0c;
  localparam logic [7:0] ADDR_ACT_DLY   = 8'h10;
  localparam logic [7:0] ADDR_REL_DLY   = 8'h14;
  localparam logic [7:0] ADDR_ALLOC     = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_ST    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;

  // control field positions
  localparam int CTRL_HIGH_EN = 0;
  localparam int CTRL_LOW_EN  = 1;

  // status field positions
  localparam int ST_COND   = 0;
  localparam int ST_ALARM  = 1;
  localparam int ST_HIGH   = 2;
  localparam int ST_LOW    = 3;
  localparam int ST_ACKED  = 4;
  localparam int ST_STATE  = 5;

  // interrupt event bits
  localparam int IRQ_W       = 3;
  localparam int IRQ_RAISE   = 0;
  localparam int IRQ_RELEASE = 1;
  localparam int IRQ_ACK     = 2;

  // reset values and limits
  localparam logic [31:0] OFF_CODE       = 32'h8000_0000;
  localparam logic [15:0] DEADBAND_RST   = 16'h000a;
  localparam logic [15:0] DEADBAND_MAX   = 16'hc350;
  localparam logic [15:0] DELAY_RST      = 16'h0000;
  localparam int          TICK_MS        = 100;
  localparam int          DELAY_MAX_S    = 5000;
  localparam logic [15:0] DELAY_MAX      =
    16'(DELAY_MAX_S * 1000 / TICK_MS);
  localparam logic [6:0]  ALLOC_RST      = 7'h00;
  localparam logic [3:0]  FLASH_TICKS    = 4'h5;

  // alarm sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE    = 2'b00,
    SAC_ACTIVE  = 2'b01,
    SAC_RELEASE = 2'b11
  } sac_state_t;

endpackage

// ---- verilog/sac_cmp.sv ----
// one setpoint comparator with deadband hold
// assumes value, setpoint and band steady between clock edges
`timescale 1ns/1ps
`default_nettype none
module sac_cmp #(
  parameter bit ABOVE = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        en_i,
  input  wire logic [31:0] value_i,
  input  wire logic [31:0] setp_i,
  input  wire logic [15:0] band_i,
  output logic             zone_o
);

  logic signed [33:0] v_s;
  logic signed [33:0] s_s;
  logic signed [33:0] b_s;
  logic               trip;
  logic               hold;
  logic               zone_q;

  // widened signed operands so the band never overflows
  assign v_s  = {{2{value_i[31]}}, value_i};
  assign s_s  = {{2{setp_i[31]}}, setp_i};
  assign b_s  = {18'h0_0000, band_i};
  assign trip = ABOVE ? (v_s >= s_s) : (v_s <= s_s);
  assign hold = ABOVE ? (v_s >= s_s - b_s) : (v_s <= s_s + b_s);
  assign zone_o = en_i & (zone_q ? hold : trip);

  // remembered zone selects the hold threshold
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      zone_q <= 1'b0;
    else
      zone_q <= zone_o;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CMP_HOLD: assert property (
    (zone_q && en_i && hold) |-> zone_o)
    else $error("zone dropped inside deadband");
  AST_CMP_OFF: assert property (
    !en_i |-> !zone_o ##1 !zone_q)
    else $error("disabled setpoint gave a zone");

endmodule
`default_nettype wire

// ---- verilog/sac_timer.sv ----
// tick counting delay timer, cleared whenever its run input drops
// assumes tick_i is a one-cycle pulse from a shared timebase
`timescale 1ns/1ps
`default_nettype none
module sac_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] limit_i,
  output logic             done_o
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // elapsed ticks compared with the limit in the same units
  assign done_o = run_i & (cnt_q >= limit_i);
  assign cnt_d  = !run_i ? 16'h0000 :
                  (tick_i && !done_o) ? cnt_q + 16'h0001 : cnt_q;

  // count register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TMR_CLEAR: assert property (
    !run_i |=> cnt_q == 16'h0000)
    else $error("timer not cleared on interruption");
  AST_TMR_TICK: assert property (
    (run_i && !tick_i) |=> $stable(cnt_q) || !$past(run_i))
    else $error("timer moved without a tick");

endmodule
`default_nettype wire

// ---- verilog/sac_top.sv ----
// setpoint alarm channel: comparators, delays, relays and annunciator
// assumes a classic wishbone master and a one-cycle 0.1 s tick input
//
// Contract
// - high setpoint enabled: value at or above it means alarm condition
// - low setpoint enabled: value at or below it means alarm condition
// - setpoints start disabled, never alarm, and read back as off
// - both enabled, high above low: alarm outside the band
// - high programmed below low: alarm inside the band
// - allocated relays follow the active alarm and release with it
// - annunciator flashes when active, steady after acknowledge
// - high alarm holds until value falls below setpoint minus band
// - low alarm holds until value rises above setpoint plus band
// - one deadband for both alarms, 0 to 50000, reset value 10
// - alarm activates only after condition lasts the whole trip time
// - trip timer clears if condition drops before the delay ends
// - one trip time for both setpoints, zero means immediate
// - relay held for a release delay, restarted if condition returns
`timescale 1ns/1ps
`default_nettype none
module sac_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [31:0] display_value_i,
  input  wire logic        tick_i,
  input  wire logic        ack_button_i,
  output logic             alarm_o,
  output logic      [6:0]  relay_o,
  output logic             annunciator_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0]        ctrl_q;
  logic [31:0]       high_setpoint_q;
  logic [31:0]       low_setpoint_q;
  logic [15:0]       alarm_deadband_q;
  logic [15:0]       activation_delay_q;
  logic [15:0]       release_delay_q;
  logic [6:0]        relay_allocation_q;
  logic [2:0]        irq_st_q;
  logic [2:0]        irq_st_d;
  logic [2:0]        irq_mask_q;
  sac_pkg::sac_state_t state_q;
  sac_pkg::sac_state_t state_d;
  logic              acked_q;
  logic              acked_d;
  logic              btn_q;
  logic [3:0]        blink_cnt_q;
  logic              blink_q;
  logic [31:0]       wmask;
  logic              bus_req;
  logic              bus_wr;
  logic [31:0]       rd_mux;
  logic              wr_ctrl;
  logic              wr_high;
  logic              wr_low;
  logic              wr_band;
  logic              wr_act;
  logic              wr_rel;
  logic              wr_alloc;
  logic              wr_irq_st;
  logic              wr_mask;
  logic [31:0]       m_ctrl;
  logic [31:0]       m_high;
  logic [31:0]       m_low;
  logic [31:0]       m_band;
  logic [31:0]       m_act;
  logic [31:0]       m_rel;
  logic [31:0]       m_alloc;
  logic [31:0]       m_mask;
  logic [15:0]       band_wr;
  logic [15:0]       act_wr;
  logic [15:0]       rel_wr;
  logic              high_en;
  logic              low_en;
  logic              high_zone;
  logic              low_zone;
  logic              overlap;
  logic              cond;
  logic              act_run;
  logic              act_done;
  logic              rel_run;
  logic              rel_done;
  logic              press;
  logic [2:0]        ev;
  logic [2:0]        w1c;
  logic [31:0]       status_word;

  ////////////////////////////////////////////////////////////////////
  // wishbone decode and byte lane merge

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i;
  assign wr_ctrl   = bus_wr & (wb_adr_i == sac_pkg::ADDR_CTRL);
  assign wr_high   = bus_wr & (wb_adr_i == sac_pkg::ADDR_HIGH);
  assign wr_low    = bus_wr & (wb_adr_i == sac_pkg::ADDR_LOW);
  assign wr_band   = bus_wr & (wb_adr_i == sac_pkg::ADDR_DEADBAND);
  assign wr_act    = bus_wr & (wb_adr_i == sac_pkg::ADDR_ACT_DLY);
  assign wr_rel    = bus_wr & (wb_adr_i == sac_pkg::ADDR_REL_DLY);
  assign wr_alloc  = bus_wr & (wb_adr_i == sac_pkg::ADDR_ALLOC);
  assign wr_irq_st = bus_wr & (wb_adr_i == sac_pkg::ADDR_IRQ_ST);
  assign wr_mask   = bus_wr & (wb_adr_i == sac_pkg::ADDR_IRQ_MASK);

  // merged words: old bits where a lane is not selected
  assign m_ctrl  = ({30'h0000_0000, ctrl_q} & ~wmask) | (wb_dat_i & wmask);
  assign m_high  = (high_setpoint_q & ~wmask) | (wb_dat_i & wmask);
  assign m_low   = (low_setpoint_q & ~wmask) | (wb_dat_i & wmask);
  assign m_band  = ({16'h0000, alarm_deadband_q} & ~wmask)
                 | (wb_dat_i & wmask);
  assign m_act   = ({16'h0000, activation_delay_q} & ~wmask)
                 | (wb_dat_i & wmask);
  assign m_rel   = ({16'h0000, release_delay_q} & ~wmask)
                 | (wb_dat_i & wmask);
  assign m_alloc = ({25'h000_0000, relay_allocation_q} & ~wmask)
                 | (wb_dat_i & wmask);
  assign m_mask  = ({29'h0000_0000, irq_mask_q} & ~wmask)
                 | (wb_dat_i & wmask);
  assign w1c     = wr_irq_st ? (wb_dat_i[2:0] & wmask[2:0]) : 3'h0;

  // out of range values saturate at the documented limits
  assign band_wr = (m_band > {16'h0000, sac_pkg::DEADBAND_MAX}) ?
                   sac_pkg::DEADBAND_MAX : m_band[15:0];
  assign act_wr  = (m_act > {16'h0000, sac_pkg::DELAY_MAX}) ?
                   sac_pkg::DELAY_MAX : m_act[15:0];
  assign rel_wr  = (m_rel > {16'h0000, sac_pkg::DELAY_MAX}) ?
                   sac_pkg::DELAY_MAX : m_rel[15:0];

  ////////////////////////////////////////////////////////////////////
  // read mux; disabled setpoints read as the off code

  assign status_word = {25'h000_0000, state_q, acked_q, low_zone,
                        high_zone, (state_q != sac_pkg::SAC_IDLE), cond};
  assign rd_mux =
    (wb_adr_i == sac_pkg::ADDR_CTRL)     ? {30'h0000_0000, ctrl_q} :
    (wb_adr_i == sac_pkg::ADDR_HIGH)     ?
      (high_en ? high_setpoint_q : sac_pkg::OFF_CODE) :
    (wb_adr_i == sac_pkg::ADDR_LOW)      ?
      (low_en ? low_setpoint_q : sac_pkg::OFF_CODE) :
    (wb_adr_i == sac_pkg::ADDR_DEADBAND) ? {16'h0000, alarm_deadband_q} :
    (wb_adr_i == sac_pkg::ADDR_ACT_DLY)  ? {16'h0000, activation_delay_q} :
    (wb_adr_i == sac_pkg::ADDR_REL_DLY)  ? {16'h0000, release_delay_q} :
    (wb_adr_i == sac_pkg::ADDR_ALLOC)    ?
      {25'h000_0000, relay_allocation_q} :
    (wb_adr_i == sac_pkg::ADDR_STATUS)   ? status_word :
    (wb_adr_i == sac_pkg::ADDR_IRQ_ST)   ? {29'h0000_0000, irq_st_q} :
    (wb_adr_i == sac_pkg::ADDR_IRQ_MASK) ? {29'h0000_0000, irq_mask_q} :
    32'h0000_0000;

  // bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q             <= 2'h0;
      high_setpoint_q    <= 32'h0000_0000;
      low_setpoint_q     <= 32'h0000_0000;
      alarm_deadband_q   <= sac_pkg::DEADBAND_RST;
      activation_delay_q <= sac_pkg::DELAY_RST;
      release_delay_q    <= sac_pkg::DELAY_RST;
      relay_allocation_q <= sac_pkg::ALLOC_RST;
      irq_mask_q         <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= m_ctrl[1:0];
      if (wr_high)
        high_setpoint_q <= m_high;
      if (wr_low)
        low_setpoint_q <= m_low;
      if (wr_band)
        alarm_deadband_q <= band_wr;
      if (wr_act)
        activation_delay_q <= act_wr;
      if (wr_rel)
        release_delay_q <= rel_wr;
      if (wr_alloc)
        relay_allocation_q <= m_alloc[6:0];
      if (wr_mask)
        irq_mask_q <= m_mask[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // setpoint comparison and band selection

  assign high_en = ctrl_q[sac_pkg::CTRL_HIGH_EN];
  assign low_en  = ctrl_q[sac_pkg::CTRL_LOW_EN];

  sac_cmp #(.ABOVE(1'b1)) u_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (high_en),
    .value_i (display_value_i),
    .setp_i  (high_setpoint_q),
    .band_i  (alarm_deadband_q),
    .zone_o  (high_zone)
  );

  sac_cmp #(.ABOVE(1'b0)) u_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (low_en),
    .value_i (display_value_i),
    .setp_i  (low_setpoint_q),
    .band_i  (alarm_deadband_q),
    .zone_o  (low_zone)
  );

  // overlapping setpoints alarm inside the band, else outside it
  assign overlap = high_en & low_en &
                   ($signed(high_setpoint_q) < $signed(low_setpoint_q));
  assign cond    = overlap ? (high_zone & low_zone)
                           : (high_zone | low_zone);

  ////////////////////////////////////////////////////////////////////
  // trip and release delays

  assign act_run = cond & (state_q == sac_pkg::SAC_IDLE);
  assign rel_run = ~cond & (state_q == sac_pkg::SAC_RELEASE);

  sac_timer u_act (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (act_run),
    .tick_i  (tick_i),
    .limit_i (activation_delay_q),
    .done_o  (act_done)
  );

  sac_timer u_rel (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (rel_run),
    .tick_i  (tick_i),
    .limit_i (release_delay_q),
    .done_o  (rel_done)
  );

  // alarm sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sac_pkg::SAC_IDLE:
        if (act_done)
          state_d = sac_pkg::SAC_ACTIVE;
      sac_pkg::SAC_ACTIVE:
        if (!cond)
          state_d = (release_delay_q == sac_pkg::DELAY_RST) ?
                    sac_pkg::SAC_IDLE : sac_pkg::SAC_RELEASE;
      sac_pkg::SAC_RELEASE:
        if (cond)
          state_d = sac_pkg::SAC_ACTIVE;
        else if (rel_done)
          state_d = sac_pkg::SAC_IDLE;
      default:
        state_d = sac_pkg::SAC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // acknowledge, flashing and events

  assign press   = ack_button_i & ~btn_q;
  assign acked_d = (state_q == sac_pkg::SAC_ACTIVE) & cond &
                   (acked_q | press);
  assign ev[sac_pkg::IRQ_RAISE]   = (state_q == sac_pkg::SAC_IDLE) &
                                    (state_d != sac_pkg::SAC_IDLE);
  assign ev[sac_pkg::IRQ_RELEASE] = (state_q != sac_pkg::SAC_IDLE) &
                                    (state_d == sac_pkg::SAC_IDLE);
  assign ev[sac_pkg::IRQ_ACK]     = press & ~acked_q &
                                    (state_q == sac_pkg::SAC_ACTIVE);
  assign irq_st_d = (irq_st_q & ~w1c) | ev;   // set wins over clear

  // sequencer, acknowledge and flash timing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q     <= sac_pkg::SAC_IDLE;
      acked_q     <= 1'b0;
      btn_q       <= 1'b0;
      blink_cnt_q <= 4'h0;
      blink_q     <= 1'b0;
      irq_st_q    <= 3'h0;
    end
    else
    begin
      state_q  <= state_d;
      acked_q  <= acked_d;
      btn_q    <= ack_button_i;
      irq_st_q <= irq_st_d;
      if (tick_i)
      begin
        blink_cnt_q <= (blink_cnt_q == sac_pkg::FLASH_TICKS - 4'h1) ?
                       4'h0 : blink_cnt_q + 4'h1;
        if (blink_cnt_q == sac_pkg::FLASH_TICKS - 4'h1)
          blink_q <= ~blink_q;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_o       <= 1'b0;
      relay_o       <= 7'h00;
      annunciator_o <= 1'b0;
      irq_o         <= 1'b0;
    end
    else
    begin
      alarm_o       <= (state_d != sac_pkg::SAC_IDLE);
      relay_o       <= (state_d != sac_pkg::SAC_IDLE) ?
                       relay_allocation_q : 7'h00;
      annunciator_o <= (state_d == sac_pkg::SAC_ACTIVE) &
                       (acked_d | blink_q);
      irq_o         <= |(irq_st_d & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_HIGH_TRIP: assert property (
    (high_en && !overlap &&
     $signed(display_value_i) >= $signed(high_setpoint_q)) |-> cond)
    else $error("high setpoint reached without condition");
  AST_LOW_TRIP: assert property (
    (low_en && !overlap &&
     $signed(display_value_i) <= $signed(low_setpoint_q)) |-> cond)
    else $error("low setpoint reached without condition");
  AST_OFF_QUIET: assert property (
    (!high_en && !low_en) |-> !cond)
    else $error("condition with both setpoints off");
  AST_BAND_OUT: assert property (
    (high_en && low_en && !overlap && !high_zone && !low_zone) |-> !cond)
    else $error("condition inside the normal band");
  AST_BAND_IN: assert property (
    (overlap && !(high_zone && low_zone)) |-> !cond)
    else $error("overlap alarm outside the band");
  AST_RELAY: assert property (
    (state_d != sac_pkg::SAC_IDLE) |=>
      relay_o == $past(relay_allocation_q))
    else $error("allocated relay not driven");
  AST_RELAY_OFF: assert property (
    (state_q == sac_pkg::SAC_IDLE && state_d == sac_pkg::SAC_IDLE)
      |=> relay_o == 7'h00)
    else $error("relay driven while idle");
  AST_STEADY: assert property (
    (acked_q && state_q == sac_pkg::SAC_ACTIVE && cond) |=> annunciator_o)
    else $error("acknowledged annunciator not steady");
  AST_BAND_MAX: assert property (
    alarm_deadband_q <= sac_pkg::DEADBAND_MAX)
    else $error("deadband above limit");
  AST_TRIP_WAIT: assert property (
    (state_q == sac_pkg::SAC_IDLE && !act_done) |=>
      state_q == sac_pkg::SAC_IDLE)
    else $error("alarm raised before trip time");
  AST_ZERO_TRIP: assert property (
    (state_q == sac_pkg::SAC_IDLE && cond &&
     activation_delay_q == sac_pkg::DELAY_RST) |=>
      state_q == sac_pkg::SAC_ACTIVE ##0 alarm_o)
    else $error("zero trip time not immediate");
  AST_RESTART: assert property (
    (state_q == sac_pkg::SAC_RELEASE && cond) |=>
      state_q == sac_pkg::SAC_ACTIVE)
    else $error("release delay not restarted");

endmodule
`default_nettype wire

// ---- tb/sac_far.sv ----
// far side: relay coils and the annunciator lamp
// assumes registered drives from the alarm channel
`timescale 1ns/1ps
`default_nettype none
module sac_far (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [6:0]  relay_i,
  input  wire logic        led_i,
  output logic      [6:0]  coil_o,
  output logic      [15:0] flips_o
);
  logic led_q;

  // coils follow drives, lamp changes counted
  always_ff @(posedge clk_i)
  begin
    coil_o <= relay_i;
    led_q  <= led_i;
    if (rst_i)
      flips_o <= 16'h0;
    else
      flips_o <= flips_o + {15'h0, led_q ^ led_i};
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the setpoint alarm channel
// assumes a classic wishbone slave answering within 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0]  c;
    logic [31:0] h;
    logic [31:0] l;
    logic [31:0] v;
    logic        a;
  } sac_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        tick = 1'b0, btn = 1'b0;
  logic        ack, alarm, led, irq;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dat = 32'h0, val = 32'h0, rdat, q;
  logic [6:0]  relay, coil;
  logic [15:0] flips, f0;
  int          error_cnt = 0;
  int          comparisons = 0;
  // mode, high, low, value, expected alarm
  sac_row_t    rows [10] = '{
    '{2'h0, 32'h64, 32'ha, 32'hc8, 1'b0},
    '{2'h1, 32'h64, 32'ha, 32'h64, 1'b1},
    '{2'h1, 32'h64, 32'ha, 32'h63, 1'b0},
    '{2'h2, 32'h64, 32'ha, 32'ha, 1'b1},
    '{2'h2, 32'h64, 32'ha, 32'hffff_fffb, 1'b1},
    '{2'h2, 32'h64, 32'ha, 32'hb, 1'b0},
    '{2'h3, 32'h64, 32'ha, 32'h32, 1'b0},
    '{2'h3, 32'h64, 32'ha, 32'h65, 1'b1},
    '{2'h3, 32'ha, 32'h64, 32'h32, 1'b1},
    '{2'h3, 32'ha, 32'h64, 32'hc8, 1'b0}};

  sac_top u_sac_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .display_value_i(val), .tick_i(tick), .ack_button_i(btn),
    .alarm_o(alarm), .relay_o(relay), .annunciator_o(led), .irq_o(irq));
  sac_far u_sac_far (.clk_i(clk_i), .rst_i(rst_i), .relay_i(relay),
    .led_i(led), .coil_o(coil), .flips_o(flips));

  // 100 MHz clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one bus cycle, request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      tally_and_finish;
    end
    else
      @(posedge clk_i);
  endtask

  task automatic setv(input logic [31:0] v, input logic a);
    val <= v;
    cyc_n(3);
    chk("alarm", alarm, a);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      cyc_n(2);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    cyc_n(8);
    rst_i <= 1'b0;
    cyc_n(1);
    chk("alarm", alarm, 0);
    wb(1'b0, sac_pkg::ADDR_DEADBAND, 0);
    chk("band", q, 32'ha);
    wb(1'b0, sac_pkg::ADDR_HIGH, 0);
    chk("high", q, 32'h8000_0000);
    wb(1'b0, sac_pkg::ADDR_ACT_DLY, 0);
    chk("trip", q, 32'h0);
    wb(1'b0, 8'h30, 0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, sac_pkg::ADDR_DEADBAND, 32'hffff);
    wb(1'b0, sac_pkg::ADDR_DEADBAND, 0);
    chk("band max", q, 32'hc350);
    $display("reset test done");
    // table of setpoint modes
    wb(1'b1, sac_pkg::ADDR_DEADBAND, 0);
    wb(1'b1, sac_pkg::ADDR_ALLOC, 32'h55);
    wb(1'b1, sac_pkg::ADDR_IRQ_MASK, 32'h1);
    foreach (rows[i])
    begin
      wb(1'b1, sac_pkg::ADDR_HIGH, rows[i].h);
      wb(1'b1, sac_pkg::ADDR_LOW, rows[i].l);
      wb(1'b1, sac_pkg::ADDR_CTRL, {30'h0, rows[i].c});
      setv(rows[i].v, rows[i].a);
      chk("relay", relay, rows[i].a ? 32'h55 : 32'h0);
    end
    chk("irq", irq, 1);
    wb(1'b1, sac_pkg::ADDR_IRQ_ST, 32'h1);
    chk("irq clr", irq, 0);
    $display("table test done");
    // deadband hold on both sides
    wb(1'b1, sac_pkg::ADDR_DEADBAND, 32'ha);
    wb(1'b1, sac_pkg::ADDR_HIGH, 32'h64);
    wb(1'b1, sac_pkg::ADDR_LOW, 32'ha);
    wb(1'b1, sac_pkg::ADDR_CTRL, 32'h1);
    setv(32'h64, 1'b1);
    setv(32'h5a, 1'b1);
    setv(32'h59, 1'b0);
    wb(1'b1, sac_pkg::ADDR_CTRL, 32'h2);
    setv(32'ha, 1'b1);
    setv(32'h14, 1'b1);
    setv(32'h15, 1'b0);
    $display("deadband test done");
    // trip delay, broken and then whole
    wb(1'b1, sac_pkg::ADDR_DEADBAND, 0);
    wb(1'b1, sac_pkg::ADDR_ACT_DLY, 32'h3);
    wb(1'b1, sac_pkg::ADDR_CTRL, 32'h1);
    setv(32'h64, 1'b0);
    ticks(2);
    setv(32'h0, 1'b0);
    setv(32'h64, 1'b0);
    ticks(2);
    chk("alarm", alarm, 0);
    ticks(1);
    cyc_n(2);
    chk("alarm", alarm, 1);
    $display("trip test done");
    // flashing, then steady after the button
    f0 = flips;
    ticks(20);
    cyc_n(2);  // lamp model counts the last toggle two edges later
    chk("flashes", flips - f0, 4);
    btn <= 1'b1;
    cyc_n(3);
    f0 = flips;
    ticks(7);
    chk("steady", led, 1);
    chk("no flash", flips - f0, 0);
    btn <= 1'b0;
    $display("annunciator test done");
    // release delay restarted by a returning condition
    wb(1'b1, sac_pkg::ADDR_ACT_DLY, 0);
    wb(1'b1, sac_pkg::ADDR_REL_DLY, 32'h2);
    wb(1'b1, sac_pkg::ADDR_IRQ_ST, 32'h7);
    setv(32'h0, 1'b1);
    chk("led off", led, 0);
    ticks(1);
    setv(32'h64, 1'b1);
    setv(32'h0, 1'b1);
    ticks(1);
    chk("alarm", alarm, 1);
    ticks(1);
    cyc_n(2);
    chk("alarm", alarm, 0);
    chk("relay", relay, 0);
    chk("coil", coil, 0);
    wb(1'b0, sac_pkg::ADDR_IRQ_ST, 0);
    chk("released", q[1], 1);
    $display("release test done");
    // reset in mid-run, taken while the alarm is active
    setv(32'h64, 1'b1);
    rst_i <= 1'b1;
    cyc_n(2);
    rst_i <= 1'b0;
    cyc_n(1);
    chk("alarm rst", alarm, 0);
    chk("relay rst", relay, 0);
    wb(1'b0, sac_pkg::ADDR_REL_DLY, 0);
    chk("rel rst", q, 0);
    $display("second reset test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
